// ---- bench/tb_sequence_voltage_element.sv ----
`timescale 1ns/10ps
module tb_sequence_voltage_element;
  // ****************************************
  // stimulus and observed signals
  // ****************************************
  localparam int T = 4;
  logic ref_clk = 1'b0;
  logic reset = 1'b1;
  logic ce = 1'b1;
  logic signed [15:0] va_re = 16'h0000, va_im = 16'h0000, vb_re = 16'h0000;
  logic signed [15:0] vb_im = 16'h0000, vc_re = 16'h0000, vc_im = 16'h0000;
  logic function_enable = 1'b1, ratio_enable = 1'b0;
  logic [1:0] mode = 2'h1;
  logic [7:0] threshold = 8'h64, ratio_pct = 8'h00;
  logic [15:0] delay_ms = 16'h0000;
  logic ext_block_permit = 1'b0, ext_trip_block_permit = 1'b0, permanent_trip_block = 1'b0;
  logic ext_block_input_a = 1'b0, ext_block_input_b = 1'b0, ext_trip_block_input = 1'b0;
  logic block_a_assigned = 1'b0, block_b_assigned = 1'b0, trip_block_assigned = 1'b0;
  logic active, ext_blocked, trip_cmd_blocked, alarm, trip, trip_cmd;
  int error_cnt = 0;
  int n_tests = 0;
  int cycles = 0;
  int k;

  typedef struct {logic [1:0] md; logic [7:0] thr; logic ren; logic [7:0] pct; int p; int n; logic al;} row_s;
  // positive and negative amplitudes, 4096 = nominal
  row_s rows [15] = '{
    '{2'h1, 8'h64, 1'b0, 8'h00, 4915, 0, 1'b1}, '{2'h1, 8'h64, 1'b0, 8'h00, 3277, 0, 1'b0},
    '{2'h2, 8'h64, 1'b0, 8'h00, 3277, 0, 1'b1}, '{2'h2, 8'h64, 1'b0, 8'h00, 4915, 0, 1'b0},
    '{2'h3, 8'h0A, 1'b0, 8'h00, 4096, 820, 1'b1}, '{2'h3, 8'h0A, 1'b0, 8'h00, 4096, 205, 1'b0},
    '{2'h3, 8'h0A, 1'b1, 8'h1E, 4096, 820, 1'b0}, '{2'h3, 8'h0A, 1'b1, 8'h0A, 4096, 820, 1'b1},
    '{2'h0, 8'h64, 1'b0, 8'h00, 4915, 0, 1'b0}, '{2'h1, 8'hC8, 1'b0, 8'h00, 4915, 0, 1'b0},
    '{2'h1, 8'h01, 1'b0, 8'h00, 100, 0, 1'b1}, '{2'h2, 8'h01, 1'b0, 8'h00, 100, 0, 1'b0},
    '{2'h3, 8'h0A, 1'b0, 8'h00, 4096, 0, 1'b0}, '{2'h2, 8'h00, 1'b0, 8'h00, 20, 0, 1'b1},
    '{2'h2, 8'hFF, 1'b0, 8'h00, 9000, 0, 1'b0}};

  always #12.5 ref_clk = ~ref_clk;

  sequence_voltage_element #(.TICK_CYCLES(T)) uut (.ref_clk(ref_clk), .reset(reset), .ce(ce),
    .va_re(va_re), .va_im(va_im), .vb_re(vb_re), .vb_im(vb_im), .vc_re(vc_re), .vc_im(vc_im),
    .function_enable(function_enable), .mode(mode), .threshold(threshold), .ratio_enable(ratio_enable),
    .ratio_pct(ratio_pct), .delay_ms(delay_ms), .ext_block_permit(ext_block_permit),
    .ext_trip_block_permit(ext_trip_block_permit), .permanent_trip_block(permanent_trip_block),
    .ext_block_input_a(ext_block_input_a), .ext_block_input_b(ext_block_input_b),
    .ext_trip_block_input(ext_trip_block_input), .block_a_assigned(block_a_assigned),
    .block_b_assigned(block_b_assigned), .trip_block_assigned(trip_block_assigned), .active(active),
    .ext_blocked(ext_blocked), .trip_cmd_blocked(trip_cmd_blocked), .alarm(alarm), .trip(trip),
    .trip_cmd(trip_cmd));

  // ****************************************
  // helpers
  // ****************************************
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0)
    begin
      $display("ALL CHECKS OK");
    end
    else
    begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("BAD t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge ref_clk);
  endtask

  // balanced positive set of amplitude p plus negative set of amplitude n
  task automatic phases(input int p, input int n);
    int h;
    int d;
    h = -(p + n) / 2;
    d = ((n - p) * 14189) / 16384;
    va_re = 16'(p + n);
    vb_re = 16'(h);
    vb_im = 16'(d);
    vc_re = 16'(h);
    vc_im = 16'(-d);
  endtask

  task automatic wait_alarm();
    k = 0;
    while (alarm !== 1'b1 && k < 20)
    begin
      cyc(1);
      k++;
    end
  endtask

  // hang guard: far above the under two hundred cycles the run needs
  always @(posedge ref_clk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      error_cnt++;
      conclude();
    end
  end

  // ****************************************
  // main sequence
  // ****************************************
  initial
  begin
    phases(4915, 0);
    cyc(12);
    chk({trip_cmd, trip, alarm, active}, 8'h00);
    reset = 1'b0;
    foreach (rows[i])
    begin
      mode = rows[i].md;
      threshold = rows[i].thr;
      ratio_enable = rows[i].ren;
      ratio_pct = rows[i].pct;
      phases(rows[i].p, rows[i].n);
      cyc(4);
      chk(alarm, rows[i].al);
      chk(trip_cmd, rows[i].al);
      chk(active, rows[i].md != 2'h0);
    end
    // delay timer and restart on drop-out
    mode = 2'h1;
    threshold = 8'h64;
    delay_ms = 16'h0003;
    phases(3277, 0);
    cyc(4);
    phases(4915, 0);
    wait_alarm();
    k = 0;
    while (trip !== 1'b1 && k < 40)
    begin
      cyc(1);
      k++;
    end
    chk(k >= 3 * T - 1 && k <= 3 * T + 2, 1);
    phases(3277, 0);
    cyc(4);
    chk({alarm, trip}, 8'h00);
    phases(4915, 0);
    wait_alarm();
    cyc(8);
    phases(3277, 0);
    cyc(4);
    phases(4915, 0);
    wait_alarm();
    cyc(8);
    chk(trip, 0);
    cyc(6);
    chk(trip, 1);
    // trip command and element blocking
    delay_ms = 16'h0000;
    ext_trip_block_permit = 1'b1;
    trip_block_assigned = 1'b1;
    ext_trip_block_input = 1'b1;
    cyc(3);
    chk({trip_cmd_blocked, trip, trip_cmd}, 8'h06);
    trip_block_assigned = 1'b0;
    cyc(3);
    chk(trip_cmd, 1);
    ext_trip_block_permit = 1'b0;
    trip_block_assigned = 1'b1;
    cyc(3);
    chk(trip_cmd, 1);
    ext_trip_block_input = 1'b0;
    permanent_trip_block = 1'b1;
    cyc(3);
    chk({trip_cmd_blocked, trip, trip_cmd}, 8'h06);
    permanent_trip_block = 1'b0;
    ext_block_permit = 1'b1;
    ext_block_input_a = 1'b1;
    cyc(3);
    chk(alarm, 1);
    block_a_assigned = 1'b1;
    cyc(3);
    chk({ext_blocked, alarm, trip}, 8'h04);
    ext_block_input_a = 1'b0;
    block_b_assigned = 1'b1;
    ext_block_input_b = 1'b1;
    cyc(3);
    chk({ext_blocked, trip}, 8'h02);
    ext_block_permit = 1'b0;
    cyc(4);
    chk({ext_blocked, alarm, trip_cmd}, 8'h03);
    // clock enable low freezes the outputs
    ce = 1'b0;
    phases(3277, 0);
    cyc(4);
    chk(alarm, 1);
    ce = 1'b1;
    cyc(4);
    chk(alarm, 0);
    // function off, then a reset in mid-trip
    phases(4915, 0);
    function_enable = 1'b0;
    cyc(4);
    chk({active, alarm, trip}, 8'h00);
    function_enable = 1'b1;
    cyc(4);
    chk(trip, 1);
    reset = 1'b1;
    cyc(2);
    chk({active, alarm, trip, trip_cmd}, 8'h00);
    reset = 1'b0;
    cyc(4);
    chk({active, alarm}, 8'h03);
    conclude();
  end
endmodule // tb_sequence_voltage_element

// ---- hdl/seq_components.sv ----
`timescale 1ns/10ps
module seq_components (
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic ce,
  // phase voltage phasors
  input wire logic signed [15:0] va_re,
  input wire logic signed [15:0] va_im,
  input wire logic signed [15:0] vb_re,
  input wire logic signed [15:0] vb_im,
  input wire logic signed [15:0] vc_re,
  input wire logic signed [15:0] vc_im,
  // squared magnitudes of 3*V1 and 3*V2
  seq_if.source seq
);

  function automatic logic signed [19:0] mul_s(input logic signed [15:0] x);
    logic signed [31:0] p;
    p = $signed({{16{x[15]}}, x}) * $signed({16'h0000, seq_volt_pkg::SQRT3_HALF_Q14});
    return 20'(p >>> seq_volt_pkg::SQRT3_SHIFT);
  endfunction

  function automatic logic signed [19:0] half(input logic signed [15:0] x);
    return $signed({{4{x[15]}}, x}) >>> 1;
  endfunction

  function automatic logic [39:0] sq(input logic signed [19:0] v);
    logic signed [39:0] p;
    p = 40'(v) * 40'(v);
    return 40'(p);
  endfunction

  logic signed [19:0] pos_re;
  logic signed [19:0] pos_im;
  logic signed [19:0] neg_re;
  logic signed [19:0] neg_im;

  // sequence component sums
  // 3*V1 = Va + a*Vb + a^2*Vc, 3*V2 = Va + a^2*Vb + a*Vc
  always_comb
  begin
    pos_re = 20'(va_re) - half(vb_re) - mul_s(vb_im) - half(vc_re) + mul_s(vc_im);
    pos_im = 20'(va_im) + mul_s(vb_re) - half(vb_im) - mul_s(vc_re) - half(vc_im);
    neg_re = 20'(va_re) - half(vb_re) + mul_s(vb_im) - half(vc_re) - mul_s(vc_im);
    neg_im = 20'(va_im) - mul_s(vb_re) - half(vb_im) + mul_s(vc_re) - half(vc_im);
  end

  // squares avoid a root; thresholds are squared instead
  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      seq.pos_sq <= '0;
      seq.neg_sq <= '0;
    end
    else if (ce)
    begin
      seq.pos_sq <= sq(pos_re) + sq(pos_im);
      seq.neg_sq <= sq(neg_re) + sq(neg_im);
    end
  end

  // balanced set has no negative part
  a_balanced_neg: assert property (@(posedge ref_clk) disable iff (reset)
    ce && va_re == 16'sh1000 && va_im == 16'sh0000 && vb_re == -16'sh0800 && vb_im == -16'sh0DDB
    && vc_re == -16'sh0800 && vc_im == 16'sh0DDB |=> seq.neg_sq < 40'h00_0000_0100)
    else $error("balanced input gave negative sequence");

endmodule // seq_components

// ---- hdl/seq_if.sv ----
`timescale 1ns/10ps
interface seq_if;
  logic [39:0] pos_sq;
  logic [39:0] neg_sq;
  modport source (output pos_sq, output neg_sq);
  modport sink (input pos_sq, input neg_sq);
endinterface

// ---- hdl/seq_volt_pkg.sv ----
package seq_volt_pkg;

  // ****************************************
  // operating modes
  // ****************************************
  typedef enum logic [1:0] {
    MODE_UNUSED,
    POS_SEQ_OVERVOLTAGE_MODE,
    POS_SEQ_UNDERVOLTAGE_MODE,
    NEG_SEQ_OVERVOLTAGE_MODE
  } mode_e;

  // ****************************************
  // scaling: phasor 16'h1000 is 1.00 x nominal
  // ****************************************
  localparam logic [15:0] SQRT3_HALF_Q14 = 16'h376D;
  localparam int SQRT3_SHIFT = 14;
  localparam logic [31:0] THREE_PU = 32'h0000_3000;
  localparam logic [31:0] HUNDREDTHS = 32'h0000_0064;
  localparam logic [55:0] PCT_SQ_SCALE = 56'h00_0000_0000_2710;

  // ****************************************
  // threshold in hundredths of nominal
  // ****************************************
  localparam logic [7:0] THR_MIN = 8'h01;
  localparam logic [7:0] THR_MAX = 8'hC8;
  localparam logic [7:0] THR_RESET = 8'h64;
  localparam logic [7:0] RATIO_RESET = 8'h00;
  localparam logic [15:0] DELAY_RESET = 16'h0000;
  localparam mode_e MODE_RESET = MODE_UNUSED;

  // ****************************************
  // delay timer base: 1 ms tick
  // ****************************************
  localparam int CLK_PERIOD_NS = 25;
  localparam int TICK_TIME_NS = 1000000;
  localparam int TICK_CYCLES = TICK_TIME_NS / CLK_PERIOD_NS;

endpackage

// ---- hdl/sequence_voltage_element.sv ----
`timescale 1ns/10ps
// What this block does
// - alarm whenever selected sequence voltage is beyond threshold in supervised direction while function enabled and element not blocked
// - trip only after condition held continuously for the whole delay
// - positive and negative sequence derived from three phase voltages
// - mode selects unused, positive over, positive under or negative over; unused by default
// - in negative mode an optional negative to positive percentage criterion is ANDed in
// - with ratio enabled, trip needs negative threshold and ratio both exceeded
// - trip command suppressed when trip blocking permitted and assigned external signal true
// - element blocking acts only with assigned signal true and permission set
// - permanent trip block setting stops trip command; inactive by default
// - function enable switches element on or off; off by default
// - threshold settable 0.01 to 2.00 of nominal, default 1.00
module sequence_voltage_element #(
  parameter int TICK_CYCLES = seq_volt_pkg::TICK_CYCLES
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic ce,
  // phase voltage phasors, 16'h1000 = nominal
  input wire logic signed [15:0] va_re,
  input wire logic signed [15:0] va_im,
  input wire logic signed [15:0] vb_re,
  input wire logic signed [15:0] vb_im,
  input wire logic signed [15:0] vc_re,
  input wire logic signed [15:0] vc_im,
  // settings
  input wire logic function_enable,
  input wire logic [1:0] mode,
  input wire logic [7:0] threshold,
  input wire logic ratio_enable,
  input wire logic [7:0] ratio_pct,
  input wire logic [15:0] delay_ms,
  input wire logic ext_block_permit,
  input wire logic ext_trip_block_permit,
  input wire logic permanent_trip_block,
  // external blocking signals and whether each is assigned
  input wire logic ext_block_input_a,
  input wire logic ext_block_input_b,
  input wire logic ext_trip_block_input,
  input wire logic block_a_assigned,
  input wire logic block_b_assigned,
  input wire logic trip_block_assigned,
  // status
  output logic active,
  output logic ext_blocked,
  output logic trip_cmd_blocked,
  output logic alarm,
  output logic trip,
  output logic trip_cmd
);

  // ****************************************
  // sequence computation
  // ****************************************
  seq_if seq ();

  seq_components u_seq (
    .ref_clk(ref_clk),
    .reset(reset),
    .ce(ce),
    .va_re(va_re),
    .va_im(va_im),
    .vb_re(vb_re),
    .vb_im(vb_im),
    .vc_re(vc_re),
    .vc_im(vc_im),
    .seq(seq.source)
  );

  // ****************************************
  // settings held with defined defaults
  // ****************************************
  seq_volt_pkg::mode_e mode_q;
  logic func_q;
  logic perm_q;
  logic ratio_en_q;
  logic [7:0] thr_q;
  logic [7:0] pct_q;
  logic [15:0] delay_q;

  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      mode_q <= seq_volt_pkg::MODE_RESET;
      func_q <= 1'b0;
      perm_q <= 1'b0;
      ratio_en_q <= 1'b0;
      thr_q <= seq_volt_pkg::THR_RESET;
      pct_q <= seq_volt_pkg::RATIO_RESET;
      delay_q <= seq_volt_pkg::DELAY_RESET;
    end
    else if (ce)
    begin
      mode_q <= seq_volt_pkg::mode_e'(mode);
      func_q <= function_enable;
      perm_q <= permanent_trip_block;
      ratio_en_q <= ratio_enable;
      if (threshold < seq_volt_pkg::THR_MIN)
        thr_q <= seq_volt_pkg::THR_MIN;
      else if (threshold > seq_volt_pkg::THR_MAX)
        thr_q <= seq_volt_pkg::THR_MAX;
      else
        thr_q <= threshold;
      pct_q <= ratio_pct;
      delay_q <= delay_ms;
    end
  end

  // ****************************************
  // pickup decision
  // ****************************************
  // threshold scaled like |3*V|, then squared
  function automatic logic [39:0] thr_sq(input logic [7:0] t);
    logic [19:0] m;
    m = 20'(({24'h000000, t} * seq_volt_pkg::THREE_PU) / seq_volt_pkg::HUNDREDTHS);
    return 40'(m) * 40'(m);
  endfunction

  logic [39:0] thr_level;
  logic ratio_ok;
  logic level_ok;
  logic blk_now;
  logic trip_blk_now;
  logic enabled_now;
  logic cond_now;

  always_comb
  begin
    thr_level = thr_sq(thr_q);
    // percentage compared squared, no division; widen before multiplying
    ratio_ok = (56'(seq.neg_sq) * seq_volt_pkg::PCT_SQ_SCALE) > (56'(pct_q) * 56'(pct_q) * 56'(seq.pos_sq));
    level_ok = 1'b0;
    unique case (mode_q)
      seq_volt_pkg::MODE_UNUSED: level_ok = 1'b0;
      seq_volt_pkg::POS_SEQ_OVERVOLTAGE_MODE: level_ok = seq.pos_sq > thr_level;
      seq_volt_pkg::POS_SEQ_UNDERVOLTAGE_MODE: level_ok = seq.pos_sq < thr_level;
      // both criteria needed when ratio enabled
      seq_volt_pkg::NEG_SEQ_OVERVOLTAGE_MODE: level_ok = (seq.neg_sq > thr_level) && (!ratio_en_q || ratio_ok);
    endcase
    blk_now = ext_block_permit && ((block_a_assigned && ext_block_input_a) || (block_b_assigned && ext_block_input_b));
    trip_blk_now = perm_q || (ext_trip_block_permit && trip_block_assigned && ext_trip_block_input);
    enabled_now = func_q && (mode_q != seq_volt_pkg::MODE_UNUSED);
    cond_now = enabled_now && !blk_now && level_ok;
  end

  // ****************************************
  // delay timer on a 1 ms tick
  // ****************************************
  logic [31:0] pre_cnt;
  logic [15:0] elapsed;
  logic tick;

  always_comb
  begin
    tick = (pre_cnt == 32'(TICK_CYCLES - 1));
  end

  // prescaler restarts with the condition so each ms is whole
  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
      pre_cnt <= '0;
    else if (ce)
    begin
      if (!cond_now || tick)
        pre_cnt <= '0;
      else
        pre_cnt <= pre_cnt + 32'h0000_0001;
    end
  end

  // count whole ms of continuous pickup, saturating
  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
      elapsed <= '0;
    else if (ce)
    begin
      if (!cond_now)
        elapsed <= '0;
      else if (tick && elapsed != 16'hFFFF)
        elapsed <= elapsed + 16'h0001;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      active <= 1'b0;
      ext_blocked <= 1'b0;
      trip_cmd_blocked <= 1'b0;
      alarm <= 1'b0;
      trip <= 1'b0;
      trip_cmd <= 1'b0;
    end
    else if (ce)
    begin
      active <= enabled_now;
      ext_blocked <= enabled_now && blk_now;
      trip_cmd_blocked <= enabled_now && trip_blk_now;
      alarm <= cond_now;
      trip <= cond_now && (elapsed >= delay_q);
      trip_cmd <= cond_now && (elapsed >= delay_q) && !trip_blk_now;
    end
  end

  // ****************************************
  // checks
  // ****************************************
  sequence s_pickup_held;
    ce && cond_now;
  endsequence

  sequence s_dropped;
    ce && !cond_now;
  endsequence

  a_alarm_follows: assert property (@(posedge ref_clk) disable iff (reset)
    s_pickup_held |=> alarm)
    else $error("alarm missing while condition holds");

  a_trip_after_delay: assert property (@(posedge ref_clk) disable iff (reset)
    $rose(trip) |-> $past(elapsed) >= $past(delay_q) && alarm)
    else $error("trip before delay ran out");

  a_unused_quiet: assert property (@(posedge ref_clk) disable iff (reset)
    ce && mode_q == seq_volt_pkg::MODE_UNUSED |=> !alarm && !trip && !active)
    else $error("unused mode produced output");

  a_ratio_gate: assert property (@(posedge ref_clk) disable iff (reset)
    ce && mode_q == seq_volt_pkg::NEG_SEQ_OVERVOLTAGE_MODE && ratio_en_q && !ratio_ok |=> !alarm)
    else $error("ratio criterion ignored");

  a_neg_both: assert property (@(posedge ref_clk) disable iff (reset)
    ce && mode_q == seq_volt_pkg::NEG_SEQ_OVERVOLTAGE_MODE && !(seq.neg_sq > thr_level) |=> !trip)
    else $error("negative sequence trip below threshold");

  a_trip_cmd_block: assert property (@(posedge ref_clk) disable iff (reset)
    ce && ext_trip_block_permit && trip_block_assigned && ext_trip_block_input |=> !trip_cmd)
    else $error("trip command passed while blocked");

  a_ext_block: assert property (@(posedge ref_clk) disable iff (reset)
    ce && ext_block_permit && block_a_assigned && ext_block_input_a |=> !alarm && !trip)
    else $error("element ran while externally blocked");

  a_perm_block: assert property (@(posedge ref_clk) disable iff (reset)
    ce && perm_q |=> !trip_cmd && trip_cmd_blocked == active)
    else $error("trip command despite permanent block");

  a_func_off: assert property (@(posedge ref_clk) disable iff (reset)
    ce && !func_q |=> !active && !alarm)
    else $error("disabled element active");

  a_thr_range: assert property (@(posedge ref_clk) disable iff (reset)
    thr_q >= seq_volt_pkg::THR_MIN && thr_q <= seq_volt_pkg::THR_MAX)
    else $error("threshold outside range");

  a_timer_restart: assert property (@(posedge ref_clk) disable iff (reset)
    s_dropped |=> elapsed == 16'h0000 && !alarm && !trip)
    else $error("timer or alarm kept after dropout");

endmodule // sequence_voltage_element
